// [bench/cpwc_checker.sv]
`timescale 1ns/1ps
// ****
// port checker for the wait-state and coprocessor block
// ****
module cpwc_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cycle_start,
    input wire logic [2:0] cycle_type,
    input wire logic [7:0] io_addr,
    input wire logic io_write_strobe,
    input wire logic wide_cycle_ack_n,
    input wire logic channel_ready,
    input wire logic cycle_done_n,
    input wire logic coproc_range_sel_n,
    input wire logic coproc_busy_n,
    input wire logic coproc_chip_sel_n,
    input wire logic coproc_reset_out,
    input wire logic coproc_fault_irq,
    input wire logic cpu_wait_out_n,
    input wire logic nonmask_gate,
    input wire logic nmi_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // cycle qualifiers; memory codes all have bit 2 set
    wire io_cyc = (cycle_type == cpwc_pkg::cyc_io_read) || (cycle_type == cpwc_pkg::cyc_io_write);
    wire wide = cycle_start && cycle_type[2] && !wide_cycle_ack_n && channel_ready;
    wire narrow = cycle_start && !(cycle_type[2] && !wide_cycle_ack_n);
    chk_wide_one_wait: assert property (wide |-> ##[1:3] !cycle_done_n)
        else $error("wide cycle not ended after one wait");
    chk_narrow_four_wait: assert property (narrow |=> cycle_done_n [*4])
        else $error("narrow cycle ended before four waits");
    chk_ready_holds_off: assert property (!channel_ready [*5] |-> cycle_done_n)
        else $error("cycle ended while channel ready low");
    chk_ready_release: assert property ($rose(channel_ready) |-> ##[1:8] !cycle_done_n)
        else $error("cycle not ended after channel ready rose");
    chk_nmi_gated: assert property (!nonmask_gate [*6] |-> !nmi_out)
        else $error("nmi passed a closed gate");
    // memory cycles with the same low address must not select
    chk_select_decode: assert property (!coproc_chip_sel_n ==
        (io_cyc && !coproc_range_sel_n && io_addr[7:3] == 5'h1f))
        else $error("coprocessor select decode wrong");
    chk_busy_pass: assert property (!coproc_busy_n [*6] |-> !cpu_wait_out_n)
        else $error("busy not passed to cpu");
    chk_fault_busy: assert property (coproc_fault_irq [*2] |-> !cpu_wait_out_n)
        else $error("fault latched without busy held");
    chk_fault_sticky: assert property (coproc_fault_irq && !io_write_strobe |=> coproc_fault_irq)
        else $error("fault dropped without a port write");
    chk_reset_clear: assert property ($past(rst) |-> !coproc_fault_irq && !nmi_out)
        else $error("latches not cleared by reset");
    // reset must show while reset is asserted, so no disable here
    chk_reset_during: assert property (disable iff (1'b0) rst |-> coproc_reset_out)
        else $error("coprocessor reset missing in reset");
    chk_reset_follows: assert property (!io_write_strobe |-> !coproc_reset_out)
        else $error("coprocessor reset without a source");
    cover property (wide);
    cover property ($rose(coproc_fault_irq));
    cover property ($rose(channel_ready));
endmodule // cpwc_checker

bind cpwc_top cpwc_checker u_chk (.clk_sys, .rst, .cycle_start, .cycle_type, .io_addr, .io_write_strobe,
    .wide_cycle_ack_n, .channel_ready, .cycle_done_n, .coproc_range_sel_n, .coproc_busy_n, .coproc_chip_sel_n,
    .coproc_reset_out, .coproc_fault_irq, .cpu_wait_out_n, .nonmask_gate, .nmi_out);

// [bench/cpwc_partner.sv]
`timescale 1ns/1ps
// ****
// coprocessor and slow bus device
// ****
module cpwc_partner (
    input wire logic clk_sys,
    input wire logic busy_req,
    input wire logic err_req,
    input wire logic [11:0] stall,
    input wire logic cycle_start,
    output logic coproc_busy_n,
    output logic coproc_error_n,
    output logic channel_ready
);
    logic [11:0] left = 12'h000;
    // stall count stays under 4096 clocks so refresh is never starved
    always_ff @(posedge clk_sys) begin
        if (cycle_start) begin
            left <= stall;
        end else if (left != 12'h000) begin
            left <= left - 12'h001;
        end
    end
    // ready low until the access can be serviced, then released high
    assign channel_ready = (left == 12'h000);
    assign coproc_busy_n = !busy_req;
    assign coproc_error_n = !(err_req && busy_req);
endmodule // cpwc_partner

// [bench/testbench.sv]
`timescale 1ns/1ps
// ****
// bench for the wait-state and coprocessor block
// ****
module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cycle_start = 1'b0;
    logic [2:0] cycle_type = 3'h5;
    logic [7:0] io_addr = 8'h00;
    logic io_write_strobe = 1'b0;
    logic wide_cycle_ack_n = 1'b1;
    logic nonmask_gate = 1'b1;
    logic io_error = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic busy_req = 1'b0;
    logic err_req = 1'b0;
    logic [11:0] stall = 12'h000;
    logic [31:0] q;
    // {type, address, select_n expected}
    logic [11:0] dec [6] = '{12'h3ef, 12'h3f0, 12'h3fe, 12'h5f0, 12'hbff, 12'h3c1};
    // {type, wide ack_n}: narrow memory and i/o with the wide ack ignored
    logic [3:0] wst [4] = '{4'hb, 4'hd, 4'h2, 4'h4};
    wire channel_ready, coproc_busy_n, coproc_error_n, cycle_done_n, coproc_chip_sel_n;
    wire coproc_reset_out, coproc_fault_irq, cpu_wait_out_n, nmi_out, wb_ack_o, irq;
    wire [31:0] wb_dat_o;
    int fail_count = 0;
    int cmp_count = 0;
    int nw;
    int n;
    // outside decode of the 0f0-0ff range
    wire coproc_range_sel_n = io_addr[7:4] != 4'hf;
    cpwc_top uut (.clk_sys, .rst, .cycle_start, .cycle_type, .io_addr, .io_write_strobe, .wide_cycle_ack_n,
        .channel_ready, .cycle_done_n, .coproc_range_sel_n, .coproc_busy_n, .coproc_error_n, .coproc_chip_sel_n,
        .coproc_reset_out, .coproc_fault_irq, .cpu_wait_out_n, .io_error, .nonmask_gate, .nmi_out, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq);
    cpwc_partner u_far (.clk_sys, .busy_req, .err_req, .stall, .cycle_start, .coproc_busy_n, .coproc_error_n,
        .channel_ready);
    always #2.5 clk_sys = ~clk_sys;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do
            @(posedge clk_sys);
        while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_sys);
    endtask
    task automatic cpu(input logic [2:0] t, input logic w, input logic [11:0] s, output int c);
        {cycle_start, cycle_type, wide_cycle_ack_n, stall} <= {1'b1, t, w, s};
        @(posedge clk_sys);
        cycle_start <= 1'b0;
        c = 0;
        do begin
            @(posedge clk_sys);
            c++;
        end while (cycle_done_n !== 1'b0);
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic iow(input logic [7:0] a);
        {cycle_type, io_addr, io_write_strobe} <= {cpwc_pkg::cyc_io_write, a, 1'b1};
        repeat (2) @(posedge clk_sys);
        check("cop reset", coproc_reset_out, a == 8'hf1);
        io_write_strobe <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("cop reset off", coproc_reset_out, 1'b0);
        check("fault clear", coproc_fault_irq, 1'b0);
    endtask
    task automatic latch_err();
        {busy_req, err_req} <= 2'b11;
        repeat (8) @(posedge clk_sys);
        {busy_req, err_req} <= 2'b00;
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        check("cop reset", coproc_reset_out, 1'b1);
        rst <= 1'b0;
        @(posedge clk_sys);
        check("cop reset idle", coproc_reset_out, 1'b0);
        wb(1'b0, cpwc_pkg::adr_ctrl, 32'h0, q);
        check("ctrl", q, 32'h0000_0001);
        wb(1'b0, 8'h14, 32'h0, q);
        check("unmapped", q, cpwc_pkg::unmapped_data);
        $display("reset test done");
        cpu(3'h5, 1'b0, 12'h000, nw);
        foreach (wst[i]) begin
            cpu(wst[i][3:1], wst[i][0], 12'h000, n);
            check("waits", n, nw + 3);
        end
        cpu(3'h6, 1'b1, 12'h028, n);
        check("stretch", n >= 40, 1'b1);
        wb(1'b0, cpwc_pkg::adr_irq_stat, 32'h0, q);
        check("stretch event", q, 32'h0000_0004);
        foreach (dec[i]) begin
            {cycle_type, io_addr} <= dec[i][11:1];
            repeat (2) @(posedge clk_sys);
            check("chip sel", coproc_chip_sel_n, dec[i][0]);
        end
        $display("wait and decode tests done");
        busy_req <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check("busy pass", cpu_wait_out_n, 1'b0);
        busy_req <= 1'b0;
        repeat (8) @(posedge clk_sys);
        check("busy gone", cpu_wait_out_n, 1'b1);
        wb(1'b1, cpwc_pkg::adr_irq_en, 32'h0000_0001, q);
        latch_err();
        check("busy held", cpu_wait_out_n, 1'b0);
        check("fault irq", coproc_fault_irq, 1'b1);
        check("nmi", nmi_out, 1'b1);
        check("irq", irq, 1'b1);
        wb(1'b0, cpwc_pkg::adr_status, 32'h0, q);
        check("status", q, 32'h0000_000b);
        wb(1'b1, cpwc_pkg::adr_irq_en, 32'h0, q);
        check("irq masked", irq, 1'b0);
        iow(8'hf0);
        check("busy clear", cpu_wait_out_n, 1'b1);
        wb(1'b1, cpwc_pkg::adr_irq_clr, 32'h0000_0007, q);
        wb(1'b0, cpwc_pkg::adr_irq_stat, 32'h0, q);
        check("irq stat", q, 32'h0);
        nonmask_gate <= 1'b0;
        latch_err();
        check("nmi gated", nmi_out, 1'b0);
        iow(8'hf1);
        {nonmask_gate, io_error} <= 2'b11;
        repeat (8) @(posedge clk_sys);
        check("io nmi", nmi_out, 1'b1);
        wb(1'b1, cpwc_pkg::adr_ctrl, 32'h0, q);
        check("nmi sw gate", nmi_out, 1'b0);
        wb(1'b1, cpwc_pkg::adr_ctrl, 32'h0000_0001, q);
        io_error <= 1'b0;
        latch_err();
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check("reset clears", coproc_fault_irq, 1'b0);
        check("reset busy", cpu_wait_out_n, 1'b1);
        $display("coprocessor tests done");
        tally_and_finish();
    end
    // whole run is under 300 clocks; cut a hang at 8000 clocks, well beyond that
    initial begin
        #40000;
        fail_count++;
        tally_and_finish();
    end
endmodule // testbench

// [logic/cpwc_pkg.sv]
package cpwc_pkg;

    // ********************************************************************
    // wishbone register map (word-aligned byte addresses)
    // ********************************************************************
    localparam logic [7:0] adr_ctrl = 8'h00;
    localparam logic [7:0] adr_status = 8'h04;
    localparam logic [7:0] adr_irq_stat = 8'h08;
    localparam logic [7:0] adr_irq_clr = 8'h0c;
    localparam logic [7:0] adr_irq_en = 8'h10;
    localparam logic [31:0] unmapped_data = 32'h0000_0000;

    // ctrl fields
    localparam int ctrl_nmi_gate_bit = 0;

    // status fields
    localparam int st_busy_latch_bit = 0;
    localparam int st_fault_latch_bit = 1;
    localparam int st_busy_in_bit = 2;
    localparam int st_nmi_bit = 3;

    // event bits (irq status / clear / enable)
    localparam int ev_fault_bit = 0;
    localparam int ev_nmi_bit = 1;
    localparam int ev_stretch_bit = 2;
    localparam int ev_width = 3;
    localparam logic [2:0] ev_reset = 3'h0;

    // ********************************************************************
    // wait-state timing
    // ********************************************************************
    localparam logic [2:0] wide_waits = 3'h1;
    localparam logic [2:0] narrow_waits = 3'h4;

    // ********************************************************************
    // coprocessor port decode (i/o space)
    // ********************************************************************
    localparam logic [7:0] port_clear_busy = 8'hf0;
    localparam logic [7:0] port_reset_cop = 8'hf1;
    localparam logic [3:0] range_hi_nibble = 4'hf;
    localparam int chip_sel_bit = 3;

    // cpu cycle types from the status lines {mem_io, s1_n, s0_n}
    localparam logic [2:0] cyc_io_read = 3'h1;
    localparam logic [2:0] cyc_io_write = 3'h2;
    localparam logic [2:0] cyc_mem_read = 3'h5;
    localparam logic [2:0] cyc_mem_write = 3'h6;

    // bus cycle state machine
    typedef enum logic [2:0] {
        cpwc_idle = 3'b001,
        cpwc_wait = 3'b010,
        cpwc_done = 3'b100
    } cpwc_state_t;

endpackage

// [logic/cpwc_top.sv]
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps

module cpwc_top (
    input wire logic clk_sys,
    input wire logic rst,
    // cpu bus cycle
    input wire logic cycle_start,
    input wire logic [2:0] cycle_type,
    input wire logic [7:0] io_addr,
    input wire logic io_write_strobe,
    input wire logic wide_cycle_ack_n,
    input wire logic channel_ready,
    output logic cycle_done_n,
    // coprocessor
    input wire logic coproc_range_sel_n,
    input wire logic coproc_busy_n,
    input wire logic coproc_error_n,
    output logic coproc_chip_sel_n,
    output logic coproc_reset_out,
    output logic coproc_fault_irq,
    output logic cpu_wait_out_n,
    // nmi
    input wire logic io_error,
    input wire logic nonmask_gate,
    output logic nmi_out,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq
);

    // ********************************************************************
    // pin synchronisers (three stages, change accepted when 2 and 3 agree)
    // ********************************************************************
    logic [2:0] rdy_sync;
    logic [2:0] busy_sync;
    logic [2:0] err_sync;
    logic [2:0] ioerr_sync;
    logic [2:0] gate_sync;
    logic rdy_q;
    logic busy_q;
    logic err_q;
    logic ioerr_q;
    logic gate_q;

    // shift pins in; the first stage feeds only the second
    // the stages carry no reset: they only follow the pins and are flushed within three clocks
    always_ff @(posedge clk_sys) begin
        rdy_sync <= {rdy_sync[1:0], channel_ready};
        busy_sync <= {busy_sync[1:0], ~coproc_busy_n};
        err_sync <= {err_sync[1:0], ~coproc_error_n};
        ioerr_sync <= {ioerr_sync[1:0], io_error};
        gate_sync <= {gate_sync[1:0], nonmask_gate};
    end

    // filtered levels only move when the last two stages agree
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdy_q <= 1'b1;
            busy_q <= 1'b0;
            err_q <= 1'b0;
            ioerr_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            if (rdy_sync[1] == rdy_sync[2]) rdy_q <= rdy_sync[2];
            if (busy_sync[1] == busy_sync[2]) busy_q <= busy_sync[2];
            if (err_sync[1] == err_sync[2]) err_q <= err_sync[2];
            if (ioerr_sync[1] == ioerr_sync[2]) ioerr_q <= ioerr_sync[2];
            if (gate_sync[1] == gate_sync[2]) gate_q <= gate_sync[2];
        end
    end

    // the wait engine takes ready as soon as stages 2 and 3 agree, one clock ahead of
    // rdy_q: a device that drops ready as the cycle starts is then seen before the
    // fourth default wait ends, which the registered level would miss
    wire rdy_ok = (rdy_sync[1] == rdy_sync[2]) ? rdy_sync[2] : rdy_q;

    // ********************************************************************
    // coprocessor port decode
    // ********************************************************************
    function automatic logic is_io(input logic [2:0] t);
        is_io = (t == cpwc_pkg::cyc_io_read) || (t == cpwc_pkg::cyc_io_write);
    endfunction

    // memory cycles share the low address bits, so every decode below is gated by the
    // cycle type first; a halt or acknowledge code is neither i/o nor memory

    wire io_cycle = is_io(cycle_type);
    wire range_hit = ~coproc_range_sel_n && io_cycle
        && (io_addr[7:4] == cpwc_pkg::range_hi_nibble);
    wire io_wr = range_hit && io_write_strobe && (cycle_type == cpwc_pkg::cyc_io_write);
    wire wr_clear = io_wr && (io_addr == cpwc_pkg::port_clear_busy);
    wire wr_reset = io_wr && (io_addr == cpwc_pkg::port_reset_cop);
    wire latch_clear = wr_clear || wr_reset;
    wire cs_hit = range_hit && io_addr[cpwc_pkg::chip_sel_bit];

    // reset pulse follows its sources with no storage
    assign coproc_reset_out = rst || wr_reset;
    assign coproc_chip_sel_n = ~cs_hit;

    // ********************************************************************
    // busy / fault latches
    // ********************************************************************
    logic fault_latch;
    wire fault_set = err_q && busy_q;

    // set wins over a clear in the same cycle so no error is lost
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fault_latch <= 1'b0;
        end else if (fault_set) begin
            fault_latch <= 1'b1;
        end else if (latch_clear) begin
            fault_latch <= 1'b0;
        end
    end

    // busy output is rebuilt from fault_set too, so the held state starts in the same
    // clock as the interrupt, with no one-clock gap between pass-through and hold
    // busy passes through, and is held while the fault latch stands
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cpu_wait_out_n <= 1'b1;
            coproc_fault_irq <= 1'b0;
        end else begin
            cpu_wait_out_n <= ~(busy_q || fault_latch || fault_set);
            coproc_fault_irq <= fault_latch || fault_set;
        end
    end

    // ********************************************************************
    // nmi gating
    // ********************************************************************
    // both error sources share the pin gate; the software bit in ctrl is a second mask
    // that resets open, so a cold system behaves as if only the pin gate existed
    logic nmi_gate_sw;
    wire nmi_src = (ioerr_q || fault_latch) && gate_q && nmi_gate_sw;

    always_ff @(posedge clk_sys) begin
        if (rst) nmi_out <= 1'b0;
        else nmi_out <= nmi_src;
    end

    // ********************************************************************
    // wait-state engine
    // ********************************************************************
    cpwc_pkg::cpwc_state_t state;
    cpwc_pkg::cpwc_state_t next_state;
    logic [2:0] wait_cnt;
    logic [2:0] next_wait_cnt;
    logic stretched;

    // wide ack counts on every cycle that is not i/o, halt and acknowledge included; i/o is always narrow
    wire wide_mem = ~wide_cycle_ack_n && ~io_cycle;
    wire [2:0] load_waits = wide_mem ? cpwc_pkg::wide_waits : cpwc_pkg::narrow_waits;
    wire count_done = (wait_cnt == 3'h0);

    // limitation: a pin change needs three clocks to be seen, so a wide cycle is over
    // before a ready drop at its start can count; a slow device must answer narrow.
    // the last wait and the done decision share one clock, so the count ends at one

    always_comb begin
        next_state = state;
        next_wait_cnt = wait_cnt;
        case (state)
            cpwc_pkg::cpwc_idle: begin
                if (cycle_start) begin
                    next_state = cpwc_pkg::cpwc_wait;
                    next_wait_cnt = load_waits;
                end
            end
            cpwc_pkg::cpwc_wait: begin
                if (!count_done) next_wait_cnt = wait_cnt - 3'h1;
                // low ready keeps the cycle open with no upper bound
                if ((count_done || (wait_cnt == 3'h1)) && rdy_ok) next_state = cpwc_pkg::cpwc_done;
            end
            cpwc_pkg::cpwc_done: begin
                next_state = cpwc_pkg::cpwc_idle;
            end
            default: begin
                next_state = cpwc_pkg::cpwc_idle;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= cpwc_pkg::cpwc_idle;
            wait_cnt <= 3'h0;
        end else begin
            state <= next_state;
            wait_cnt <= next_wait_cnt;
        end
    end

    // flag a cycle that the bus device had to stretch past the default
    always_ff @(posedge clk_sys) begin
        if (rst) stretched <= 1'b0;
        else stretched <= (state == cpwc_pkg::cpwc_wait) && count_done && !rdy_ok;
    end

    assign cycle_done_n = ~(state == cpwc_pkg::cpwc_done);

    // ********************************************************************
    // interrupt status, enable, clear
    // ********************************************************************
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic nmi_prev;
    logic fault_prev;

    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    wire wr_ctrl = bus_wr && (wb_adr_i == cpwc_pkg::adr_ctrl);
    wire wr_clr = bus_wr && (wb_adr_i == cpwc_pkg::adr_irq_clr);
    wire wr_en = bus_wr && (wb_adr_i == cpwc_pkg::adr_irq_en);
    logic [2:0] ev_now;
    // one-clock pulses for the fault and nmi rises, each at its named bit;
    // the stretch flag stands on every clock of a stall
    always_comb begin
        ev_now = cpwc_pkg::ev_reset;
        ev_now[cpwc_pkg::ev_fault_bit] = fault_latch && !fault_prev;
        ev_now[cpwc_pkg::ev_nmi_bit] = nmi_src && !nmi_prev;
        ev_now[cpwc_pkg::ev_stretch_bit] = stretched;
    end
    wire [2:0] clr_mask = wr_clr ? wb_dat_i[2:0] : 3'h0;

    // new events win over a clear landing in the same cycle
    // enable writes take effect on the low three bits; upper data bits are dropped
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_stat <= cpwc_pkg::ev_reset;
            irq_en <= cpwc_pkg::ev_reset;
            nmi_prev <= 1'b0;
            fault_prev <= 1'b0;
            nmi_gate_sw <= 1'b1;
        end else begin
            irq_stat <= (irq_stat & ~clr_mask) | ev_now;
            nmi_prev <= nmi_src;
            fault_prev <= fault_latch;
            if (wr_en) irq_en <= wb_dat_i[2:0];
            if (wr_ctrl) nmi_gate_sw <= wb_dat_i[cpwc_pkg::ctrl_nmi_gate_bit];
        end
    end

    assign irq = |(irq_stat & irq_en);

    // ********************************************************************
    // wishbone read path, one-cycle ack
    // ********************************************************************
    // status fields placed by their named positions; unused bits read zero
    logic [31:0] status_word;
    always_comb begin
        status_word = cpwc_pkg::unmapped_data;
        status_word[cpwc_pkg::st_busy_latch_bit] = ~cpu_wait_out_n;
        status_word[cpwc_pkg::st_fault_latch_bit] = fault_latch;
        status_word[cpwc_pkg::st_busy_in_bit] = busy_q;
        status_word[cpwc_pkg::st_nmi_bit] = nmi_out;
    end
    wire [31:0] rd_mux =
        (wb_adr_i == cpwc_pkg::adr_ctrl) ? {31'h0, nmi_gate_sw} :
        (wb_adr_i == cpwc_pkg::adr_status) ? status_word :
        (wb_adr_i == cpwc_pkg::adr_irq_stat) ? {29'h0, irq_stat} :
        (wb_adr_i == cpwc_pkg::adr_irq_en) ? {29'h0, irq_en} :
        cpwc_pkg::unmapped_data;

    // ack follows a taken request by one clock; while it stands bus_req is low,
    // so a master that holds stb one clock too long is not taken twice
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= cpwc_pkg::unmapped_data;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_mux : cpwc_pkg::unmapped_data;
        end
    end

endmodule // cpwc_top
